// ---- design/i2c_defs.svh ----
// Shared timing and framing constants for the two-wire engine
`ifndef I2C_DEFS_SVH
`define I2C_DEFS_SVH
`define I2C_SYS_PERIOD_NS 20
`define I2C_SCL_PERIOD_NS 10000
`define I2C_QTR_CYC (`I2C_SCL_PERIOD_NS / (4 * `I2C_SYS_PERIOD_NS))
`define I2C_ACK_BIT 4'h8
`define I2C_FRAME_END 4'h9
`define I2C_BIT_ZERO 4'h0
`define I2C_STEP_SDA 3'h0
`define I2C_STEP_REL 3'h1
`define I2C_STEP_HIGH 3'h2
`define I2C_STEP_MID 3'h3
`define I2C_STEP_LAST 3'h4
`define I2C_DIR_READ 1'b1
`define I2C_LINE_LOW 1'b0
`define I2C_FIFO_DEPTH 8
`define I2C_CMD_W 11
`endif

// ---- design/i2c_pkg.sv ----
// Types shared by both ends of the two-wire engine
package i2c_pkg;
    typedef enum logic [1:0] {
        OP_START = 2'b00,
        OP_WRITE = 2'b01,
        OP_READ = 2'b10,
        OP_STOP = 2'b11
    } i2c_op_e;
    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_COND = 3'b001,
        M_BYTE = 3'b010,
        M_LOST = 3'b011
    } mst_state_e;
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_ADDR = 2'b01,
        S_RX = 2'b10,
        S_TX = 2'b11
    } slv_state_e;
endpackage : i2c_pkg

// ---- design/i2c_bus_if.sv ----
// Open-drain two-wire bus joining master end, slave end and bench drivers
`timescale 1ns/1ps
interface i2c_bus_if;
    logic scl_m_o, scl_m_oe, sda_m_o, sda_m_oe;
    logic scl_s_o, scl_s_oe, sda_s_o, sda_s_oe;
    logic ext_scl_oe, ext_sda_oe;
    logic scl, sda;
    // --------------------------------
    // Wired-AND with pull-up
    // --------------------------------
    assign scl = !((scl_m_oe && !scl_m_o) || (scl_s_oe && !scl_s_o) || ext_scl_oe);
    assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o) || ext_sda_oe);
    modport master (output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe,
        input scl, input sda);
    modport slave (output scl_s_o, output scl_s_oe, output sda_s_o, output sda_s_oe,
        input scl, input sda);
endinterface : i2c_bus_if

// ---- design/i2c_fifo.sv ----
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`include "i2c_defs.svh"
module i2c_fifo #(
    parameter int WIDTH = `I2C_CMD_W,
    parameter int DEPTH = `I2C_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0] cnt_q;
    logic push, pop;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];
    assign out_valid = (cnt_q != '0);
    // --------------------------------
    // Storage, one slot per entry
    // --------------------------------
    genvar gi;
    for (gi = 0; gi < DEPTH; gi++) begin : g_slot
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                mem_q[gi] <= '0;
            end else if (push && (wr_q == AW'(gi))) begin
                mem_q[gi] <= in_data;
            end
        end
    end
    // --------------------------------
    // Pointers and fill level
    // --------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
            // Registered ready: full is known one cycle ahead
            in_ready <= ((cnt_q + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH));
        end
    end
endmodule : i2c_fifo

// ---- design/i2c_slave_end.sv ----
// Slave end: address match, receive and transmit with clock stretching
`timescale 1ns/1ps
`include "i2c_defs.svh"
module i2c_slave_end #(
    parameter logic [6:0] OWN_ADDR = 7'h2A
) (
    input wire logic clk_sys,
    input wire logic rstn,
    i2c_bus_if.slave bus,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic addressed,
    output logic rd_mode
);
    import i2c_pkg::*;
    slv_state_e state_q;
    logic scl_m1, scl_s, scl_p, sda_m1, sda_s, sda_p;
    logic rise, fall, start_det, stop_det, need_q, mack_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    // --------------------------------
    // Line synchronisers
    // --------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {scl_m1, scl_s, scl_p} <= 3'h7;
            {sda_m1, sda_s, sda_p} <= 3'h7;
        end else begin
            {scl_m1, scl_s, scl_p} <= {bus.scl, scl_m1, scl_s}; // RQ22
            {sda_m1, sda_s, sda_p} <= {bus.sda, sda_m1, sda_s};
        end
    end
    assign rise = scl_s && !scl_p; // RQ10
    assign fall = !scl_s && scl_p;
    assign start_det = scl_s && scl_p && sda_p && !sda_s; // RQ7
    assign stop_det = scl_s && scl_p && !sda_p && sda_s; // RQ8
    assign bus.scl_s_o = `I2C_LINE_LOW; // RQ1
    assign bus.sda_s_o = `I2C_LINE_LOW;
    // --------------------------------
    // Protocol state machine
    // --------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= S_IDLE;
            cnt_q <= `I2C_BIT_ZERO;
            sh_q <= 8'h00;
            bus.sda_s_oe <= 1'b0;
            bus.scl_s_oe <= 1'b0;
            need_q <= 1'b0;
            mack_q <= 1'b0;
            tx_ready <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            addressed <= 1'b0;
            rd_mode <= 1'b0;
        end else begin
            tx_ready <= 1'b0;
            rx_valid <= 1'b0;
            if (start_det) begin
                // Repeated start resets slave logic too
                state_q <= S_ADDR; // RQ13
                cnt_q <= `I2C_BIT_ZERO;
                bus.sda_s_oe <= 1'b0;
                bus.scl_s_oe <= 1'b0;
                need_q <= 1'b0;
                addressed <= 1'b0;
            end else if (stop_det) begin
                state_q <= S_IDLE;
                bus.sda_s_oe <= 1'b0;
                bus.scl_s_oe <= 1'b0;
                need_q <= 1'b0;
                addressed <= 1'b0;
            end else if (need_q) begin
                // Hold SCL low until a byte is offered
                if (tx_valid) begin // RQ15
                    sh_q <= tx_data;
                    bus.sda_s_oe <= !tx_data[7]; // RQ4
                    tx_ready <= 1'b1;
                    need_q <= 1'b0;
                end
            end else if (state_q != S_IDLE) begin
                bus.scl_s_oe <= 1'b0;
                if (rise) begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q < `I2C_ACK_BIT) begin
                        sh_q <= {sh_q[6:0], sda_s}; // RQ4
                        if (state_q == S_TX && !bus.sda_s_oe && sh_q[7] && !sda_s) begin
                            state_q <= S_IDLE; // RQ17
                        end
                    end else begin
                        mack_q <= !sda_s;
                    end
                end else if (fall) begin
                    if (cnt_q == `I2C_ACK_BIT) begin
                        case (state_q)
                            S_ADDR: begin
                                if (sh_q[7:1] == OWN_ADDR) begin
                                    bus.sda_s_oe <= 1'b1; // RQ5
                                    rd_mode <= (sh_q[0] == `I2C_DIR_READ); // RQ3
                                end else begin
                                    state_q <= S_IDLE;
                                end
                            end
                            S_RX: begin
                                bus.sda_s_oe <= 1'b1; // RQ11
                                rx_valid <= 1'b1;
                                rx_data <= sh_q;
                            end
                            default: bus.sda_s_oe <= 1'b0; // RQ21
                        endcase
                    end else if (cnt_q == `I2C_FRAME_END) begin
                        cnt_q <= `I2C_BIT_ZERO;
                        bus.sda_s_oe <= 1'b0;
                        if (state_q == S_ADDR) begin
                            addressed <= 1'b1;
                            state_q <= rd_mode ? S_TX : S_RX; // RQ6
                            need_q <= rd_mode;
                            bus.scl_s_oe <= rd_mode;
                        end else if (state_q == S_TX) begin
                            state_q <= mack_q ? S_TX : S_IDLE; // RQ12
                            need_q <= mack_q;
                            bus.scl_s_oe <= mack_q; // RQ15
                        end
                    end else if (state_q == S_TX) begin
                        bus.sda_s_oe <= !sh_q[7]; // RQ9
                    end
                end
            end
        end
    end
endmodule : i2c_slave_end

// ---- design/i2c_master_end.sv ----
// Master end: command queue, start/stop, byte framing, arbitration
`timescale 1ns/1ps
`include "i2c_defs.svh"
// Contract
// [RQ1] Lines only pulled low or released
// [RQ2] Start, address, then direction bit
// [RQ3] Direction one reads, zero writes
// [RQ4] Bytes shifted most significant first
// [RQ5] Addressed slave pulls acknowledge low
// [RQ6] Roles follow direction after address
// [RQ7] Start: data falls, clock high
// [RQ8] Stop: data rises, clock high
// [RQ9] Data changes only with clock low
// [RQ10] Sample on clock rise; master clocks
// [RQ11] Write: slave acknowledges every byte
// [RQ12] Read: master acks, stop ends
// [RQ13] Repeated start keeps the bus
// [RQ14] Single and combined messages supported
// [RQ15] Clock stretching: master waits released clock
// [RQ16] Track busy; no start while busy
// [RQ17] Mismatch loses arbitration, release lines
// [RQ18] Loser waits for stop, winner continues
// [RQ19] Lower address wins; same continues
// [RQ20] Nine clocks: eight data, one ack
// [RQ21] After eighth fall, release, read ack
// [RQ22] Synchronise lines, detect from samples
module i2c_master_end #(
    parameter int QTR = `I2C_QTR_CYC,
    parameter int DEPTH = `I2C_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rstn,
    i2c_bus_if.master bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire i2c_pkg::i2c_op_e cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_nack,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_ack,
    output logic arb_lost,
    output logic bus_busy
);
    import i2c_pkg::*;
    localparam int QW = $clog2(QTR + 1);
    mst_state_e state_q;
    logic scl_m1, scl_s, scl_p, sda_m1, sda_s, sda_p;
    logic start_det, stop_det, tick, own_q, stop_q, is_read_q, pop, q_valid;
    logic [QW-1:0] qcnt_q;
    logic [2:0] step_q;
    logic [3:0] bit_q;
    logic [8:0] tx_q, rx_q;
    logic [`I2C_CMD_W-1:0] q_data;
    i2c_op_e q_op;
    // --------------------------------
    // Command queue
    // --------------------------------
    // Engine pops only when idle, so a slow bus back-pressures the user
    i2c_fifo #(.WIDTH(`I2C_CMD_W), .DEPTH(DEPTH)) u_cmd_fifo (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data({cmd_op, cmd_nack, cmd_data}),
        .out_valid(q_valid),
        .out_ready(pop),
        .out_data(q_data)
    );
    assign q_op = i2c_op_e'(q_data[10:9]);
    assign pop = q_valid && (state_q == M_IDLE) && !(q_op == OP_START && bus_busy && !own_q); // RQ16
    assign bus.scl_m_o = `I2C_LINE_LOW; // RQ1
    assign bus.sda_m_o = `I2C_LINE_LOW;
    // --------------------------------
    // Line synchronisers and conditions
    // --------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {scl_m1, scl_s, scl_p} <= 3'h7;
            {sda_m1, sda_s, sda_p} <= 3'h7;
        end else begin
            {scl_m1, scl_s, scl_p} <= {bus.scl, scl_m1, scl_s}; // RQ22
            {sda_m1, sda_s, sda_p} <= {bus.sda, sda_m1, sda_s};
        end
    end
    assign start_det = scl_s && scl_p && sda_p && !sda_s; // RQ7
    assign stop_det = scl_s && scl_p && !sda_p && sda_s; // RQ8
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bus_busy <= 1'b0;
        end else if (start_det) begin
            bus_busy <= 1'b1; // RQ16
        end else if (stop_det) begin
            bus_busy <= 1'b0;
        end
    end
    // --------------------------------
    // Quarter-bit divider
    // --------------------------------
    // Reloads while a released clock is still held low, so the high
    // phase is measured from the real rise, not from our release
    assign tick = (qcnt_q == '0);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            qcnt_q <= QW'(QTR - 1);
        end else if (tick || state_q == M_IDLE || (step_q == `I2C_STEP_HIGH && !scl_s)) begin
            qcnt_q <= QW'(QTR - 1); // RQ15
        end else begin
            qcnt_q <= qcnt_q - 1'b1;
        end
    end
    // --------------------------------
    // Engine
    // --------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= M_IDLE;
            step_q <= `I2C_STEP_SDA;
            bit_q <= `I2C_BIT_ZERO;
            tx_q <= 9'h000;
            rx_q <= 9'h000;
            own_q <= 1'b0;
            stop_q <= 1'b0;
            is_read_q <= 1'b0;
            bus.scl_m_oe <= 1'b0;
            bus.sda_m_oe <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_ack <= 1'b0;
            arb_lost <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            arb_lost <= 1'b0;
            case (state_q)
                M_IDLE: begin
                    step_q <= `I2C_STEP_SDA;
                    bit_q <= `I2C_BIT_ZERO;
                    if (pop) begin
                        case (q_op)
                            OP_START: begin
                                state_q <= M_COND; // RQ2
                                stop_q <= 1'b0;
                            end
                            OP_STOP: begin
                                state_q <= own_q ? M_COND : M_IDLE;
                                stop_q <= 1'b1;
                            end
                            OP_WRITE: begin
                                // Address byte is a write too: addr and dir bit
                                state_q <= own_q ? M_BYTE : M_IDLE; // RQ14
                                tx_q <= {q_data[7:0], 1'b1}; // RQ21
                                is_read_q <= 1'b0;
                            end
                            default: begin
                                state_q <= own_q ? M_BYTE : M_IDLE;
                                tx_q <= {8'hFF, q_data[8]}; // RQ12
                                is_read_q <= 1'b1;
                            end
                        endcase
                    end
                end
                M_COND: begin
                    if (tick || (step_q == `I2C_STEP_HIGH && scl_s)) begin
                        step_q <= step_q + 1'b1;
                        case (step_q)
                            `I2C_STEP_SDA: bus.sda_m_oe <= stop_q; // RQ9
                            `I2C_STEP_REL: bus.scl_m_oe <= 1'b0;
                            `I2C_STEP_HIGH: step_q <= `I2C_STEP_MID;
                            `I2C_STEP_MID: bus.sda_m_oe <= !stop_q; // RQ7 RQ8
                            default: begin
                                bus.scl_m_oe <= !stop_q;
                                own_q <= !stop_q; // RQ13
                                state_q <= M_IDLE;
                            end
                        endcase
                    end
                end
                M_BYTE: begin
                    if (tick || (step_q == `I2C_STEP_HIGH && scl_s)) begin
                        step_q <= step_q + 1'b1;
                        case (step_q)
                            `I2C_STEP_SDA: bus.sda_m_oe <= !tx_q[8]; // RQ4 RQ9
                            `I2C_STEP_REL: bus.scl_m_oe <= 1'b0; // RQ10
                            `I2C_STEP_HIGH: begin
                                rx_q <= {rx_q[7:0], sda_s}; // RQ10
                                if (!is_read_q && bit_q < `I2C_ACK_BIT && tx_q[8] && !sda_s) begin
                                    // Lower address or data wins; release both
                                    state_q <= M_LOST; // RQ17 RQ19
                                    bus.sda_m_oe <= 1'b0;
                                    own_q <= 1'b0;
                                    arb_lost <= 1'b1;
                                end
                            end
                            default: begin
                                bus.scl_m_oe <= 1'b1;
                                step_q <= `I2C_STEP_SDA;
                                tx_q <= {tx_q[7:0], 1'b1};
                                bit_q <= bit_q + 1'b1;
                                if (bit_q == `I2C_ACK_BIT) begin
                                    state_q <= M_IDLE; // RQ20
                                    rsp_valid <= 1'b1;
                                    rsp_data <= rx_q[8:1];
                                    rsp_ack <= !rx_q[0]; // RQ5 RQ11
                                end
                            end
                        endcase
                    end
                end
                M_LOST: begin
                    bus.scl_m_oe <= 1'b0;
                    bus.sda_m_oe <= 1'b0;
                    if (stop_det) begin
                        state_q <= M_IDLE; // RQ18
                    end
                end
                default: state_q <= M_IDLE;
            endcase
        end
    end
endmodule : i2c_master_end

// ---- testbench/i2c_bus_props.sv ----
// Bus checker for the two-wire link
`timescale 1ns/1ps
module i2c_bus_props (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_m_o,
    input wire logic sda_m_o,
    input wire logic scl_s_o,
    input wire logic sda_s_o,
    input wire logic scl_m_oe,
    input wire logic sda_m_oe,
    input wire logic scl_s_oe,
    input wire logic sda_s_oe
);
    // ----
    // Bit tracking
    // ----
    logic scl_q, sda_q, first_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    wire rise = scl && !scl_q;
    wire start = scl && scl_q && sda_q && !sda;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end
    // Raw lines, not synchronised: drivers are flops of this clock
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 4'h0;
            first_q <= 1'b0;
            sh_q <= 8'h00;
        end else if (start) begin
            cnt_q <= 4'h0;
            first_q <= 1'b1;
        end else if (rise) begin
            cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
            first_q <= first_q && (cnt_q != 4'h8);
            sh_q <= {sh_q[6:0], sda};
        end
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence seq_m_start;
        $rose(sda_m_oe) && scl;
    endsequence
    sequence seq_m_clock_low;
        $rose(scl_m_oe);
    endsequence
    a_open_drain_only: assert property (!scl_m_o && !sda_m_o && !scl_s_o && !sda_s_o)
        else $error("line driven high");
    a_start_then_clock: assert property (seq_m_start |-> ##[3:7] seq_m_clock_low)
        else $error("no clock low after start");
    a_stop_release: assert property ($fell(sda_m_oe) && scl |=> (!sda_m_oe && !scl_m_oe)[*4])
        else $error("master active after stop");
    a_slave_sda_low: assert property ($changed(sda_s_oe) |-> !scl)
        else $error("slave data moved with clock high");
    a_stretch_wait: assert property (seq_m_clock_low |-> $past(scl) && $past(scl, 4))
        else $error("clock pulled before seen high");
    a_ack_slot_free: assert property (rise && cnt_q == 4'h8 && first_q |-> !sda_m_oe)
        else $error("master holds data in ack slot");
    a_addr_ack: assert property (rise && cnt_q == 4'h8 && first_q && sh_q[7:1] == 7'h2A
        |-> sda_s_oe)
        else $error("own address not acknowledged");
    a_slave_no_clock: assert property ($rose(scl_s_oe) |-> !$past(scl))
        else $error("slave pulled a high clock");
endmodule : i2c_bus_props

// ---- testbench/testbench.sv ----
// Self-checking bench for both ends of the two-wire link
`timescale 1ns/1ps
module testbench;
    import i2c_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic cmd_valid = 1'b0, cmd_nack = 1'b0, tx_en = 1'b0;
    i2c_op_e cmd_op = OP_STOP;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ready, rsp_valid, rsp_ack, arb_lost, bus_busy;
    logic tx_ready, rx_valid, addressed, rd_mode;
    logic [7:0] rsp_data, rx_data;
    logic [2:0] tx_idx = 3'h0;
    logic [8:0] rsp_q[$];
    logic [7:0] rx_q[$];
    int want_r, want_x;
    int err_total = 0;
    int n_tests = 0;
    i2c_bus_if bus();
    always #10 clk_sys = ~clk_sys;
    // ----
    // Both ends and checker
    // ----
    i2c_master_end #(.QTR(5)) i_i2c_master_end (.clk_sys(clk_sys), .rstn(rstn), .bus(bus),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
        .cmd_nack(cmd_nack), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack),
        .arb_lost(arb_lost), .bus_busy(bus_busy));
    i2c_slave_end i_i2c_slave_end (.clk_sys(clk_sys), .rstn(rstn), .bus(bus),
        .tx_valid(tx_en), .tx_data(tx_idx[0] ? 8'h5A : 8'hC3), .tx_ready(tx_ready),
        .rx_valid(rx_valid), .rx_data(rx_data), .addressed(addressed), .rd_mode(rd_mode));
    i2c_bus_props i_i2c_bus_props (.clk_sys(clk_sys), .rstn(rstn), .scl(bus.scl),
        .sda(bus.sda), .scl_m_o(bus.scl_m_o), .sda_m_o(bus.sda_m_o), .scl_s_o(bus.scl_s_o),
        .sda_s_o(bus.sda_s_o), .scl_m_oe(bus.scl_m_oe), .sda_m_oe(bus.sda_m_oe),
        .scl_s_oe(bus.scl_s_oe), .sda_s_oe(bus.sda_s_oe));
    always @(posedge clk_sys) begin
        if (rsp_valid === 1'b1) rsp_q.push_back({rsp_ack, rsp_data});
        if (rx_valid === 1'b1) rx_q.push_back(rx_data);
        if (tx_ready === 1'b1) tx_idx <= tx_idx + 3'h1;
    end
    // ----
    // Helpers
    // ----
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict;
        if (err_total == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    function automatic bit cond(input int k);
        case (k)
            0: return rsp_q.size() >= want_r && rx_q.size() >= want_x;
            1: return bus_busy === 1'b0;
            2: return bus.sda_m_oe === 1'b1;
            3: return arb_lost === 1'b1;
            default: return addressed === 1'b1 && rd_mode === 1'b1;
        endcase
    endfunction : cond
    // Bounded wait; a hang ends the run as a mismatch
    task automatic wait_ev(input int k);
        int n;
        n = 0;
        while (!cond(k) && n < 20000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 20000) begin
            err_total++;
            $display("[FAIL] %0t wait %0d ran out", $time, k);
            give_verdict();
        end
    endtask : wait_ev
    // Valid stays up between commands so it is never written twice in one step
    task automatic push(input i2c_op_e op, input logic [7:0] d, input logic nk);
        int n;
        n = 0;
        cmd_op <= op;
        cmd_data <= d;
        cmd_nack <= nk;
        cmd_valid <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (cmd_ready !== 1'b1 && n < 20000);
        if (cmd_ready !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t push ran out", $time);
            give_verdict();
        end
    endtask : push
    task automatic check_q(input logic [8:0] er[$], input logic [7:0] ex[$]);
        want_r = er.size();
        want_x = ex.size();
        wait_ev(0);
        foreach (er[i]) chk(rsp_q[i], er[i]);
        foreach (ex[i]) chk({1'b0, rx_q[i]}, {1'b0, ex[i]});
        rsp_q.delete();
        rx_q.delete();
    endtask : check_q
    // ----
    // Scenarios
    // ----
    task automatic t_fill_write;
        bus.ext_sda_oe <= 1'b1;
        repeat (10) @(posedge clk_sys);
        bus.ext_scl_oe <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chk(9'(bus_busy), 9'h1);
        push(OP_START, 8'h00, 1'b0);
        push(OP_WRITE, 8'h54, 1'b0);
        for (int i = 0; i < 5; i++) push(OP_WRITE, 8'h01 << i, 1'b0);
        push(OP_STOP, 8'h00, 1'b0);
        cmd_valid <= 1'b0;
        @(posedge clk_sys);
        chk(9'({cmd_ready, bus.sda_m_oe}), 9'h0);
        bus.ext_scl_oe <= 1'b0;
        repeat (10) @(posedge clk_sys);
        bus.ext_sda_oe <= 1'b0;
        check_q('{9'h154, 9'h101, 9'h102, 9'h104, 9'h108, 9'h110},
            '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10});
        wait_ev(1);
    endtask : t_fill_write
    task automatic t_combined_read;
        push(OP_START, 8'h00, 1'b0);
        push(OP_WRITE, 8'h54, 1'b0);
        push(OP_WRITE, 8'h11, 1'b0);
        push(OP_START, 8'h00, 1'b0);
        push(OP_WRITE, 8'h55, 1'b0);
        push(OP_READ, 8'h00, 1'b0);
        push(OP_READ, 8'h00, 1'b1);
        push(OP_STOP, 8'h00, 1'b0);
        cmd_valid <= 1'b0;
        wait_ev(4);
        // Slave holds the clock until it has a byte to send
        repeat (60) @(posedge clk_sys);
        chk(9'({bus.scl, bus_busy, rd_mode}), 9'h3);
        tx_en <= 1'b1;
        check_q('{9'h154, 9'h111, 9'h155, 9'h1C3, 9'h05A}, '{8'h11});
        wait_ev(1);
        tx_en <= 1'b0;
    endtask : t_combined_read
    task automatic t_arbitration;
        push(OP_START, 8'h00, 1'b0);
        push(OP_WRITE, 8'h80, 1'b0);
        cmd_valid <= 1'b0;
        wait_ev(2);
        // Rival master sends address zero, so it must win
        bus.ext_sda_oe <= 1'b1;
        wait_ev(3);
        repeat (4) @(posedge clk_sys);
        chk(9'({bus.sda_m_oe, bus.scl_m_oe, bus_busy}), 9'h1);
        push(OP_START, 8'h00, 1'b0);
        push(OP_WRITE, 8'h54, 1'b0);
        push(OP_WRITE, 8'h77, 1'b0);
        push(OP_STOP, 8'h00, 1'b0);
        cmd_valid <= 1'b0;
        repeat (40) @(posedge clk_sys);
        chk(9'(bus.sda_m_oe), 9'h0);
        rsp_q.delete();
        rx_q.delete();
        bus.ext_scl_oe <= 1'b1;
        repeat (10) @(posedge clk_sys);
        bus.ext_scl_oe <= 1'b0;
        repeat (10) @(posedge clk_sys);
        bus.ext_sda_oe <= 1'b0;
        check_q('{9'h154, 9'h177}, '{8'h77});
        wait_ev(1);
    endtask : t_arbitration
    initial begin
        bus.ext_scl_oe = 1'b0;
        bus.ext_sda_oe = 1'b0;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        // Synchronisers settle before any bus activity
        repeat (6) @(posedge clk_sys);
        t_fill_write();
        t_combined_read();
        t_arbitration();
        chk(9'(cmd_ready), 9'h1);
        give_verdict();
    end
endmodule : testbench
